// [design/ptm_pkg.sv]
// constants, field layout and codes of the 10-bit periodic timer
// assumes an apb slave wrapper at byte addresses, one byte register per word
// Operation
// - ten-bit up-counter compared continuously with compare A and compare P
// - counter returns to zero when run enable rises; software cannot change it otherwise
// - overflow or selected comparator match clears the counter and raises a request
// - count hold freezes the counter; releasing it resumes from the held value
// - three-bit selector picks system, high-speed, timebase or external edge count clock
// - run enable low stops counting; counter keeps its residual value
// - compare-match mode: run enable rising puts output at its initial level
// - two-bit mode: compare, capture, pwm/single pulse, timer; timer leaves pin undriven
// - compare-match mode: action on A match is none, low, high or toggle
// - pwm mode: action is inactive, active, pwm waveform or single pulse
// - capture mode: capture on rising, falling, both edges or disabled
// - a requested level equal to the present level leaves the pin unchanged
// - level control sets initial or active level; no effect in timer mode
// - invert bit inverts the pin signal; no effect in timer mode
// - capture source is timer pins when zero, external count input when one
// - compare-match and timer modes: clear source A match when one, else P match or overflow if P is zero
// - counter reads as low byte and two-bit high byte, upper bits zero
// - compare A writable only with auto adjust off; both bytes reset to zero
// - compare A writes go direct when off, else wait for the next reload
// - with auto adjust on, each reload loads compare A from the adjust value
// - pwm period is compare P clocks, or 1024 clocks when compare P is zero
// - in compare-match and timer modes with clear source one, the compare P flag is never raised
package ptm_pkg;
  localparam int         CNT_W      = 10;
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFF_CTRL0  = 8'h00;
  localparam logic [7:0] OFF_CTRL1  = 8'h04;
  localparam logic [7:0] OFF_CNT_L  = 8'h08;
  localparam logic [7:0] OFF_CNT_H  = 8'h0C;
  localparam logic [7:0] OFF_CMPA_L = 8'h10;
  localparam logic [7:0] OFF_CMPA_H = 8'h14;
  localparam logic [7:0] OFF_CMPP_L = 8'h18;
  localparam logic [7:0] OFF_CMPP_H = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_CONFIG = 8'h24;
  localparam int         C0_HOLD    = 7;
  localparam int         C0_CKS_LSB = 4;
  localparam int         C0_RUN     = 3;
  localparam logic [7:0] C0_MASK    = 8'hF8;
  localparam int         C1_MODE    = 6;
  localparam int         C1_IO      = 4;
  localparam int         C1_OC      = 3;
  localparam int         C1_INV     = 2;
  localparam int         C1_CAPS    = 1;
  localparam int         C1_CCLR    = 0;
  localparam int         ST_FLAG_A  = 0;
  localparam int         ST_FLAG_P  = 1;
  localparam int         CFG_ADJ    = 0;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [9:0] CMP_RST    = 10'h000;
  localparam logic [9:0] CNT_MAX    = 10'h3FF;
  localparam logic [1:0] SYS_DIV_END = 2'h3;
  localparam logic [5:0] HS16_END   = 6'h0F;
  localparam logic [5:0] HS64_END   = 6'h3F;
  typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} ptm_mode_e;
  typedef enum logic [2:0] {CKS_SYS4, CKS_SYS, CKS_HS16, CKS_HS64, CKS_TB, CKS_HS,
                            CKS_EXT_RISE, CKS_EXT_FALL} ptm_cks_e;
  typedef enum logic [1:0] {ACT_0, ACT_1, ACT_2, ACT_3} ptm_act_e;
endpackage

// [design/ptm_timer.sv]
// 10-bit periodic timer with apb register access and two timer pins
// hs_clk_en and tb_clk_en are one-cycle enables from logic on mclk;
// ext_count_in and the pin inputs are asynchronous and are synchronised here
`timescale 1ns/1ps
module ptm_timer
  import ptm_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // internal clock enables and auto adjust value
  input  wire logic        hs_clk_en,
  input  wire logic        tb_clk_en,
  input  wire logic [9:0]  adj_value,
  // external pins
  input  wire logic        ext_count_in,
  input  wire logic        tp0_in,
  output logic             tp0_out,
  output logic             tp0_oe,
  input  wire logic        tp1_in,
  output logic             tp1_out,
  output logic             tp1_oe
);

  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [9:0]  cmpa_buf;
    logic [9:0]  cmpa_act;
    logic [9:0]  cmpp;
    logic [9:0]  cnt;
    logic        out_lvl;
    logic        pin;
    logic        flag_a;
    logic        flag_p;
    logic        auto_adjust_switch;
    logic        run_d;
    logic [1:0]  pre4;
    logic [5:0]  preh;
    logic [2:0]  ext_s;
    logic [2:0]  p0_s;
    logic [2:0]  p1_s;
    logic [31:0] rdata;
  } ptm_state_s;

  ptm_state_s s_reg;
  ptm_state_s s_next;

  logic       run;
  logic       hold;
  ptm_cks_e   cks;
  ptm_mode_e  mode;
  ptm_act_e   act;
  logic       oc;
  logic       inv;
  logic       caps;
  logic       cclr;
  logic       run_rise;
  logic       ext_rise;
  logic       ext_fall;
  logic       src_tick;
  logic       count_en;
  logic [9:0] cnt_inc;
  logic       match_a;
  logic       match_p;
  logic       clr;
  logic       reload;
  logic       spm;
  logic       cap_rise;
  logic       cap_fall;
  logic       cap_evt;
  logic       pwm_act;
  logic       setup;
  logic       wr;
  logic       mapped;
  logic [7:0] rbyte;

  always_comb begin
    run      = s_reg.ctrl0[C0_RUN];
    hold     = s_reg.ctrl0[C0_HOLD];
    cks      = ptm_cks_e'(s_reg.ctrl0[C0_CKS_LSB +: 3]);
    mode     = ptm_mode_e'(s_reg.ctrl1[C1_MODE +: 2]);
    act      = ptm_act_e'(s_reg.ctrl1[C1_IO +: 2]);
    oc       = s_reg.ctrl1[C1_OC];
    inv      = s_reg.ctrl1[C1_INV];
    caps     = s_reg.ctrl1[C1_CAPS];
    cclr     = s_reg.ctrl1[C1_CCLR];
    spm      = (mode == MODE_PWM) && (act == ACT_3);
    run_rise = run && !s_reg.run_d;
    ext_rise = s_reg.ext_s[1] && !s_reg.ext_s[2];
    ext_fall = !s_reg.ext_s[1] && s_reg.ext_s[2];
    // count clock source as a one-cycle enable
    case (cks)
      CKS_SYS4:     src_tick = (s_reg.pre4 == SYS_DIV_END);
      CKS_SYS:      src_tick = 1'b1;
      CKS_HS16:     src_tick = hs_clk_en && (s_reg.preh[3:0] == HS16_END[3:0]);
      CKS_HS64:     src_tick = hs_clk_en && (s_reg.preh == HS64_END);
      CKS_TB:       src_tick = tb_clk_en;
      CKS_HS:       src_tick = hs_clk_en;
      CKS_EXT_RISE: src_tick = ext_rise;
      CKS_EXT_FALL: src_tick = ext_fall;
      default:      src_tick = 1'b0;
    endcase
    // no counting while off or held; the rising edge cycle only zeroes
    count_en = run && !hold && src_tick && !run_rise;
    cnt_inc  = s_reg.cnt + 10'h001;
    // both comparators look at the next count; zero compare P means 1024
    match_a  = count_en && (cnt_inc == s_reg.cmpa_act) && (mode != MODE_CAP);
    match_p  = count_en && (cnt_inc == s_reg.cmpp) && !spm;
    // clear source; pwm, single pulse and capture ignore the select bit
    case (mode)
      MODE_CMP, MODE_TMR: clr = cclr ? match_a : match_p;
      MODE_CAP:           clr = match_p;
      MODE_PWM:           clr = spm ? 1'b0 : match_p;
      default:            clr = 1'b0;
    endcase
    // buffered compare A takes effect at the period boundary
    reload   = clr || (count_en && (s_reg.cnt == CNT_MAX));
    // capture trigger source and edge
    cap_rise = caps ? ext_rise
                    : ((s_reg.p0_s[1] && !s_reg.p0_s[2]) || (s_reg.p1_s[1] && !s_reg.p1_s[2]));
    cap_fall = caps ? ext_fall
                    : ((!s_reg.p0_s[1] && s_reg.p0_s[2]) || (!s_reg.p1_s[1] && s_reg.p1_s[2]));
    case (act)
      ACT_0:   cap_evt = cap_rise;
      ACT_1:   cap_evt = cap_fall;
      ACT_2:   cap_evt = cap_rise || cap_fall;
      default: cap_evt = 1'b0;
    endcase
    cap_evt  = cap_evt && run && (mode == MODE_CAP);
    // pwm duty: compare A at or above the period gives a full duty
    case (act)
      ACT_0:   pwm_act = 1'b0;
      ACT_1:   pwm_act = 1'b1;
      ACT_2:   pwm_act = s_reg.cnt < s_reg.cmpa_act;
      default: pwm_act = run;
    endcase
    setup  = psel && !penable;
    wr     = psel && penable && pwrite;
    mapped = (paddr <= OFF_CONFIG) && (paddr[1:0] == 2'h0);
    // counter bytes read only, upper high-byte bits read zero
    case (paddr)
      OFF_CTRL0:  rbyte = s_reg.ctrl0 & C0_MASK;
      OFF_CTRL1:  rbyte = s_reg.ctrl1;
      OFF_CNT_L:  rbyte = s_reg.cnt[7:0];
      OFF_CNT_H:  rbyte = {6'h00, s_reg.cnt[9:8]};
      OFF_CMPA_L: rbyte = s_reg.auto_adjust_switch ? s_reg.cmpa_act[7:0] : s_reg.cmpa_buf[7:0];
      OFF_CMPA_H: rbyte = {6'h00, s_reg.auto_adjust_switch ? s_reg.cmpa_act[9:8] : s_reg.cmpa_buf[9:8]};
      OFF_CMPP_L: rbyte = s_reg.cmpp[7:0];
      OFF_CMPP_H: rbyte = {6'h00, s_reg.cmpp[9:8]};
      OFF_STATUS: rbyte = {6'h00, s_reg.flag_p, s_reg.flag_a};
      OFF_CONFIG: rbyte = {7'h00, s_reg.auto_adjust_switch};
      default:    rbyte = 8'h00;
    endcase
  end

  always_comb begin
    s_next       = s_reg;
    s_next.run_d = run;
    s_next.pre4  = s_reg.pre4 + 2'h1;
    if (hs_clk_en) begin
      s_next.preh = s_reg.preh + 6'h01;
    end
    // first stage only feeds the second
    s_next.ext_s = {s_reg.ext_s[1:0], ext_count_in};
    s_next.p0_s  = {s_reg.p0_s[1:0], tp0_in};
    s_next.p1_s  = {s_reg.p1_s[1:0], tp1_in};
    if (setup) begin
      s_next.rdata = {24'h000000, rbyte};
    end
    if (wr) begin
      case (paddr)
        OFF_CTRL0:  s_next.ctrl0 = pwdata[7:0] & C0_MASK;
        // mode and pin action assumed changed only while off
        OFF_CTRL1:  s_next.ctrl1 = pwdata[7:0];
        // compare A locked while auto adjust is on; direct only while off
        OFF_CMPA_L: begin
          if (!s_reg.auto_adjust_switch) begin
            s_next.cmpa_buf[7:0] = pwdata[7:0];
            if (!run) begin
              s_next.cmpa_act[7:0] = pwdata[7:0];
            end
          end
        end
        OFF_CMPA_H: begin
          if (!s_reg.auto_adjust_switch) begin
            s_next.cmpa_buf[9:8] = pwdata[1:0];
            if (!run) begin
              s_next.cmpa_act[9:8] = pwdata[1:0];
            end
          end
        end
        OFF_CMPP_L: s_next.cmpp[7:0] = pwdata[7:0];
        OFF_CMPP_H: s_next.cmpp[9:8] = pwdata[1:0];
        OFF_STATUS: begin
          s_next.flag_a = s_reg.flag_a && !pwdata[ST_FLAG_A];
          s_next.flag_p = s_reg.flag_p && !pwdata[ST_FLAG_P];
        end
        OFF_CONFIG: s_next.auto_adjust_switch = pwdata[CFG_ADJ];
        default:    s_next.auto_adjust_switch = s_reg.auto_adjust_switch;
      endcase
    end
    // single pulse: external edge starts it, A match ends it
    if (spm && !run && ext_rise) begin
      s_next.ctrl0[C0_RUN] = 1'b1;
    end
    if (spm && match_a) begin
      s_next.ctrl0[C0_RUN] = 1'b0;
    end
    // counter: zero on run rising, cleared at period end, else count
    if (run_rise || clr) begin
      s_next.cnt = CMP_RST;
    end else if (count_en) begin
      s_next.cnt = cnt_inc;
    end
    // reload picks the adjust value or the buffered write
    if (run && reload) begin
      s_next.cmpa_act = s_reg.auto_adjust_switch ? adj_value : s_reg.cmpa_buf;
    end
    if (cap_evt) begin
      s_next.cmpa_act = s_reg.cnt;
      s_next.cmpa_buf = s_reg.cnt;
    end
    // sticky flags; a set in the clearing cycle wins
    if (match_a || cap_evt) begin
      s_next.flag_a = 1'b1;
    end
    if (match_p && !(((mode == MODE_CMP) || (mode == MODE_TMR)) && cclr)) begin
      s_next.flag_p = 1'b1;
    end
    // compare-match output level; equal request leaves it as is
    if (mode == MODE_CMP) begin
      if (run_rise) begin
        s_next.out_lvl = oc;
      end else if (match_a) begin
        case (act)
          ACT_1:   s_next.out_lvl = 1'b0;
          ACT_2:   s_next.out_lvl = 1'b1;
          ACT_3:   s_next.out_lvl = !s_reg.out_lvl;
          default: s_next.out_lvl = s_reg.out_lvl;
        endcase
      end
    end
    // level control then inversion; registered for a clean pin
    if (mode == MODE_PWM) begin
      s_next.pin = (pwm_act ? oc : !oc) ^ inv;
    end else begin
      s_next.pin = s_reg.out_lvl ^ inv;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s_reg.rdata;
  assign tp0_out = s_reg.pin;
  assign tp1_out = s_reg.pin;
  // timer mode and capture leave the pins undriven
  assign tp0_oe  = (mode == MODE_CMP) || (mode == MODE_PWM);
  assign tp1_oe  = tp0_oe;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_RUN_RISE_ZERO: assert property (run_rise |=> s_reg.cnt == CMP_RST)
    else $error("counter not zero after run enable rise");
  AST_HOLD_FREEZE: assert property (run && hold && !run_rise |=> $stable(s_reg.cnt))
    else $error("counter moved while held");
  AST_OFF_KEEP: assert property (!run && !s_next.ctrl0[C0_RUN] |=> $stable(s_reg.cnt))
    else $error("counter moved while off");
  AST_CLEAR: assert property (clr && !run_rise |=> s_reg.cnt == CMP_RST)
    else $error("counter not cleared on match");
  AST_CMP_INIT: assert property (mode == MODE_CMP && run_rise |=> ##1 tp0_out == (oc ^ inv))
    else $error("compare output not at initial level");
  AST_NO_P_FLAG: assert property ((mode == MODE_CMP) && cclr && !s_reg.flag_p |=> !s_reg.flag_p)
    else $error("compare P flag raised with clear source A");
  AST_FLAG_STICKY: assert property (s_reg.flag_a && !(wr && paddr == OFF_STATUS) |=> s_reg.flag_a)
    else $error("flag A dropped without a clear");
  AST_TMR_NO_DRIVE: assert property (mode == MODE_TMR |-> !tp0_oe && !tp1_oe)
    else $error("pin driven in timer mode");
  AST_CNT_HIGH: assert property (setup && paddr == OFF_CNT_H |=> prdata[31:2] == 30'h0)
    else $error("counter high byte upper bits not zero");
  AST_CAPTURE: assert property (cap_evt |=> s_reg.cmpa_act == $past(s_reg.cnt))
    else $error("capture did not store the counter");
  AST_CMPA_LOCK: assert property (wr && paddr == OFF_CMPA_L && s_reg.auto_adjust_switch && !cap_evt
                                  |=> $stable(s_reg.cmpa_buf))
    else $error("compare A written while auto adjust on");
  AST_PWM_PERIOD: assert property (mode == MODE_PWM && !spm && s_reg.cmpp == CMP_RST && count_en
                                   && s_reg.cnt == CNT_MAX |=> s_reg.cnt == CMP_RST)
    else $error("pwm period with zero compare P not 1024");

endmodule

// [verif/ptm_pin_model.sv]
// pin-side model: external count pin and the two timer pins
// assumes mclk from the bench; a pin reads the timer's level while the timer drives it
`timescale 1ns/1ps
module ptm_pin_model (
  // clock
  input  wire logic mclk,
  // timer pin outputs
  input  wire logic tp0_out,
  input  wire logic tp0_oe,
  input  wire logic tp1_out,
  input  wire logic tp1_oe,
  // levels seen by the timer
  output logic      ext_count_in,
  output logic      tp0_in,
  output logic      tp1_in
);
  logic drv;
  initial begin
    ext_count_in = 1'b0;
    drv          = 1'b0;
  end
  // wire level follows whoever drives it
  assign tp0_in = tp0_oe ? tp0_out : drv;
  assign tp1_in = tp1_oe ? tp1_out : drv;
  // levels held 4 cycles so the synchroniser cannot miss one
  task automatic pulse(input bit pins, input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      if (pins) drv <= 1'b1;
      else ext_count_in <= 1'b1;
      repeat (4) @(posedge mclk);
      if (pins) drv <= 1'b0;
      else ext_count_in <= 1'b0;
    end
  endtask
endmodule

// [verif/ptm_timer_tb_top.sv]
// testbench of the periodic timer: apb tasks and directed sequences
// assumes ptm_pin_model on the pins; clock enables come from a local divider
`timescale 1ns/1ps
module ptm_timer_tb_top;
  import ptm_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v1, v2;
  logic        pready, pslverr, ext_count_in, tp0_in, tp1_in;
  logic        tp0_out, tp0_oe, tp1_out, tp1_oe;
  logic [2:0]  div;
  logic [1:0]  act;
  logic        oc, inv, lvl;
  int          errors, n_checks, n, d;

  ptm_timer dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hs_clk_en(div[0]), .tb_clk_en(&div), .adj_value(10'h055), .ext_count_in(ext_count_in),
    .tp0_in(tp0_in), .tp0_out(tp0_out), .tp0_oe(tp0_oe), .tp1_in(tp1_in), .tp1_out(tp1_out),
    .tp1_oe(tp1_oe));
  ptm_pin_model pm (.mclk(mclk), .tp0_out(tp0_out), .tp0_oe(tp0_oe), .tp1_out(tp1_out),
    .tp1_oe(tp1_oe), .ext_count_in(ext_count_in), .tp0_in(tp0_in), .tp1_in(tp1_in));

  always #10 mclk = ~mclk;
  always_ff @(posedge mclk) div <= rst ? 3'h0 : div + 3'h1;

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, v2);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 8'h00, v2);
    chk(nm, e, v2 & m);
  endtask

  initial begin
    mclk    = 1'b0;
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rchk("reset value", 8'(i * 4), 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 8'h00, v1);
    chk("unmapped err", 32'h1, {31'h0, last_err});
    // compare P 20 clears the counter and sets flag P
    wr(OFF_CMPP_L, 8'h14);
    wr(OFF_CTRL0, 8'h18);
    wr(OFF_CNT_L, 8'hFF);
    repeat (60) @(posedge mclk);
    rchk("flag P", OFF_STATUS, 32'h2, 32'h2);
    apb(1'b0, OFF_CNT_L, 8'h00, v1);
    chk("cnt below P", 32'h1, {31'h0, v1 < 20});
    rchk("cnt high", OFF_CNT_H, 32'h0, 32'hFFFFFFFF);
    wr(OFF_CTRL0, 8'h98);
    apb(1'b0, OFF_CNT_L, 8'h00, v1);
    repeat (5) @(posedge mclk);
    rchk("held cnt", OFF_CNT_L, v1, 32'hFF);
    wr(OFF_CTRL0, 8'h18);
    apb(1'b0, OFF_CNT_L, 8'h00, v2);
    chk("resumed", 32'h1, {31'h0, v2 != v1});
    wr(OFF_CTRL0, 8'h10);
    apb(1'b0, OFF_CNT_L, 8'h00, v1);
    repeat (9) @(posedge mclk);
    rchk("stopped cnt", OFF_CNT_L, v1, 32'hFF);
    // every pin action, level and inversion with compare A 10 clearing
    wr(OFF_CMPA_L, 8'h0A);
    rchk("cmpA direct", OFF_CMPA_L, 32'h0A, 32'hFF);
    for (int i = 0; i < 16; i++) begin
      {oc, inv, act} = 4'(i);
      lvl = (act == 2'b00) ? oc : (act == 2'b01) ? 1'b0 : (act == 2'b10) ? 1'b1 : ~oc;
      wr(OFF_CTRL0, 8'h10);
      wr(OFF_CTRL1, {2'b00, act, oc, inv, 2'b01});
      wr(OFF_CTRL0, 8'h18);
      repeat (3) @(posedge mclk);
      chk("initial pin", {31'h0, oc ^ inv}, {31'h0, tp0_out});
      repeat (14) @(posedge mclk);
      chk("match pin", {31'h0, lvl ^ inv}, {31'h0, tp1_out});
    end
    wr(OFF_STATUS, 8'h03);
    repeat (30) @(posedge mclk);
    rchk("no flag P", OFF_STATUS, 32'h1, 32'h3);
    // auto adjust: reload takes the adjust value, writes are refused
    wr(OFF_CONFIG, 8'h01);
    repeat (40) @(posedge mclk);
    wr(OFF_CMPA_L, 8'h33);
    rchk("cmpA adjust", OFF_CMPA_L, 32'h55, 32'hFF);
    wr(OFF_CONFIG, 8'h00);
    // timer mode on external edges
    wr(OFF_CTRL0, 8'h10);
    wr(OFF_CTRL1, 8'hC0);
    // the enables follow the mode register, so look one edge after the write lands
    @(posedge mclk);
    chk("timer oe", 32'h0, {30'h0, tp0_oe, tp1_oe});
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CTRL0, 8'h60 + 8'(i * 16));
      wr(OFF_CTRL0, 8'h68 + 8'(i * 16));
      pm.pulse(1'b0, 5);
      repeat (6) @(posedge mclk);
      rchk("edge count", OFF_CNT_L, 32'h5, 32'hFF);
    end
    // internal clock selects over 256 mclk: sys/4, hs/16, hs/64, timebase, hs (bench hs = mclk/2, tb = mclk/8)
    wr(OFF_CMPP_L, 8'h00);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 4 : (i == 1) ? 32 : (i == 2) ? 128 : (i == 3) ? 8 : 2;
      wr(OFF_CTRL0, {1'b0, 3'((i == 0) ? 0 : i + 1), 4'h0});
      wr(OFF_CTRL0, {1'b0, 3'((i == 0) ? 0 : i + 1), 4'h8});
      repeat (256) @(posedge mclk);
      apb(1'b0, OFF_CNT_L, 8'h00, v1);
      chk("clock rate", 32'h1, {31'h0, v1 + 1 >= 256 / d && v1 <= 256 / d + 1});
    end
    // pwm: period 8, duty 3, active high, over ten periods
    wr(OFF_CTRL0, 8'h10);
    wr(OFF_CTRL1, 8'hA8);
    wr(OFF_CMPP_L, 8'h08);
    wr(OFF_CMPA_L, 8'h03);
    wr(OFF_CTRL0, 8'h18);
    repeat (40) @(posedge mclk);
    n = 0;
    repeat (80) begin
      @(posedge mclk);
      n += int'(tp0_out);
    end
    chk("pwm high", 32'd30, 32'(n));
    // forced levels, then one pulse started by an external rising edge
    for (int j = 0; j < 2; j++) begin
      wr(OFF_CTRL0, 8'h10);
      wr(OFF_CTRL1, {2'b10, 2'(j), 4'h8});
      wr(OFF_CTRL0, 8'h18);
      repeat (4) @(posedge mclk);
      chk("pwm forced", 32'(j), {31'h0, tp0_out});
    end
    wr(OFF_CTRL0, 8'h10);
    wr(OFF_CTRL1, 8'hB8);
    wr(OFF_STATUS, 8'h03);
    pm.pulse(1'b0, 1);
    repeat (6) @(posedge mclk);
    rchk("pulse run", OFF_CTRL0, 32'h10, 32'hFF);
    rchk("pulse flags", OFF_STATUS, 32'h1, 32'h3);
    chk("pulse pin", 32'h0, {31'h0, tp0_out});
    // capture: edge select and trigger source
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL0, 8'h10);
      wr(OFF_CTRL1, {2'b01, (i == 1) ? 2'b11 : (i == 4) ? 2'b01 : (i == 5) ? 2'b10 : 2'b00, 2'b00,
                     i == 2 || i == 3, 1'b0});
      wr(OFF_CTRL0, 8'h18);
      wr(OFF_STATUS, 8'h03);
      pm.pulse(i != 3, 1);
      repeat (6) @(posedge mclk);
      rchk("capture flag", OFF_STATUS, {31'h0, i != 1 && i != 2}, 32'h1);
    end
    stop_test();
  end

  // whole sequence takes a few thousand cycles
  initial begin
    repeat (50000) @(posedge mclk);
    errors++;
    stop_test();
  end
endmodule
